// ---- pkg/pwg_regs.svh ----
// register offsets, field positions and reset values of the wave generator
`ifndef PWG_REGS_SVH
`define PWG_REGS_SVH

`define PWG_ADDR_HIGH_LEN   8'h00
`define PWG_ADDR_LOW_LEN    8'h01
`define PWG_LEN_MSB         2
`define PWG_LEN_RESET       3'h2
`define PWG_CNT_ONE         3'h1
`define PWG_CNT_TWO         3'h2

`endif

// ---- pkg/pwg_pkg.sv ----
// types shared by the wave generator design
package pwg_pkg;

    typedef enum logic [0:0] {
        PWG_IDLE = 1'b0,
        PWG_RUN  = 1'b1
    } pwg_mode_t;

    typedef struct packed {
        logic       strb_s1;
        logic       strb_s2;
        logic       strb_s3;
        logic [7:0] addr_s1;
        logic [7:0] addr_s2;
        logic [7:0] data_s1;
        logic [7:0] data_s2;
        logic       start_s1;
        logic       start_s2;
        logic       clr_s1;
        logic       clr_s2;
        logic [2:0] high_len;
        logic [2:0] low_len;
        logic [2:0] low_phase_counter;
        logic [2:0] high_cnt;
        logic       wave;
        logic       cend_n;
        pwg_mode_t  mode;
    } pwg_state_t;

endpackage : pwg_pkg

// ---- rtl/pwg_top.sv ----
// programmable duty wave generator with host-written phase lengths
`timescale 1ns/1ps
`include "pwg_regs.svh"

module pwg_top
    import pwg_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       host_strobe_n,
    input  wire logic [7:0] host_addr,
    input  wire logic [7:0] host_data,
    input  wire logic       start_n,
    input  wire logic       quiesce_clear,
    output logic            wave_out,
    output logic            count_end_pulse_n
);

    pwg_state_t q_r;
    pwg_state_t q_nxt;

    logic       wr_fire;
    logic       start_on;
    logic       clear_on;
    logic [2:0] act_cnt;

    // ------------------------------------------------------------
    // pin synchronisers and host write decode
    // ------------------------------------------------------------
    // address and data ride two stages, matching the first two of the strobe's three, so a
    // strobe edge always meets the address that came with it
    assign wr_fire  = q_r.strb_s3 & ~q_r.strb_s2;
    assign start_on = ~q_r.start_s2;
    assign clear_on = q_r.clr_s2;
    assign act_cnt  = q_r.wave ? q_r.high_cnt : q_r.low_phase_counter;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        q_nxt          = q_r;
        q_nxt.strb_s1  = host_strobe_n;
        q_nxt.strb_s2  = q_r.strb_s1;
        q_nxt.strb_s3  = q_r.strb_s2;
        q_nxt.addr_s1  = host_addr;
        q_nxt.addr_s2  = q_r.addr_s1;
        q_nxt.data_s1  = host_data;
        q_nxt.data_s2  = q_r.data_s1;
        q_nxt.start_s1 = start_n;
        q_nxt.start_s2 = q_r.start_s1;
        q_nxt.clr_s1   = quiesce_clear;
        q_nxt.clr_s2   = q_r.clr_s1;

        // undecoded addresses fall through and leave both lengths alone
        if (wr_fire && q_r.addr_s2 == `PWG_ADDR_HIGH_LEN) begin
            q_nxt.high_len = q_r.data_s2[`PWG_LEN_MSB:0];
        end
        if (wr_fire && q_r.addr_s2 == `PWG_ADDR_LOW_LEN) begin
            q_nxt.low_len = q_r.data_s2[`PWG_LEN_MSB:0];
        end

        // clear wins over start and parks the sequence until the next start
        if (clear_on) begin
            q_nxt.wave   = 1'b0;
            q_nxt.cend_n = 1'b1;
            q_nxt.mode   = PWG_IDLE;
        end else if (start_on) begin
            // start held low keeps reloading, so the low phase counts from release
            q_nxt.wave    = 1'b0;
            q_nxt.low_phase_counter = q_r.low_len;
            q_nxt.cend_n  = 1'b1;
            q_nxt.mode    = PWG_RUN;
        end else begin
            case (q_r.mode)
                PWG_IDLE: begin
                    q_nxt.cend_n = 1'b1;
                end
                PWG_RUN: begin
                    // the counter of the current phase steps on every base clock edge, the other holds until the pulse end reloads it
                    if (q_r.wave) begin
                        q_nxt.high_cnt = q_r.high_cnt - 3'h1;
                    end else begin
                        q_nxt.low_phase_counter = q_r.low_phase_counter - 3'h1;
                    end
                    if (!q_r.cend_n) begin
                        // pulse ends: rising edge toggles the wave
                        q_nxt.cend_n = 1'b1;
                        q_nxt.wave   = ~q_r.wave;
                        if (q_r.wave) begin
                            q_nxt.low_phase_counter = q_r.low_len;
                        end else begin
                            q_nxt.high_cnt = q_r.high_len;
                        end
                    end else if (act_cnt <= `PWG_CNT_TWO) begin
                        // lengths below two fall into this branch too and act as two
                        q_nxt.cend_n = 1'b0;
                    end
                end
                default: begin
                    q_nxt.mode = PWG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q_r          <= '0;
            q_r.strb_s1  <= 1'b1;
            q_r.strb_s2  <= 1'b1;
            q_r.strb_s3  <= 1'b1;
            q_r.start_s1 <= 1'b1;
            q_r.start_s2 <= 1'b1;
            q_r.high_len <= `PWG_LEN_RESET;
            q_r.low_len  <= `PWG_LEN_RESET;
            q_r.cend_n   <= 1'b1;
            q_r.mode     <= PWG_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign wave_out          = q_r.wave;
    assign count_end_pulse_n = q_r.cend_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [3:0] hold_r;
    logic [2:0] exp_r;

    // cycles the wave has held its level, and the length loaded for it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_r <= 4'h0;
            exp_r  <= 3'h0;
        end else if (q_nxt.wave != q_r.wave || start_on || clear_on) begin
            hold_r <= 4'h1;
            exp_r  <= q_nxt.wave ? q_nxt.high_cnt : q_nxt.low_phase_counter;
        end else if (hold_r != 4'hF) begin
            hold_r <= hold_r + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // phase checks skip edges made by start or clear: those cut a phase short
    a_low_phase_len: assert property (
        $rose(q_r.wave) && $past(q_r.mode == PWG_RUN) && !$past(start_on || clear_on)
        |-> $past(hold_r) == {1'b0, $past(exp_r)} || $past(exp_r) < `PWG_CNT_TWO)
        else $error("low phase length wrong");
    a_high_phase_len: assert property (
        $fell(q_r.wave) && !$past(start_on || clear_on)
        |-> $past(hold_r) == {1'b0, $past(exp_r)} || $past(exp_r) < `PWG_CNT_TWO)
        else $error("high phase length wrong");
    a_start_loads: assert property (
        start_on && !clear_on |=> !wave_out && q_r.low_phase_counter == $past(q_r.low_len))
        else $error("start did not load low phase");
    a_pulse_at_one: assert property (
        $fell(count_end_pulse_n) |-> act_cnt == `PWG_CNT_ONE || $past(act_cnt) < 3'h2)
        else $error("count end dropped off count one");
    a_pulse_one_cycle: assert property (
        !count_end_pulse_n |=> count_end_pulse_n)
        else $error("count end low longer than one cycle");
    a_toggle_on_rise: assert property (
        !count_end_pulse_n && !start_on && !clear_on |=> wave_out != $past(wave_out))
        else $error("wave did not toggle after count end");
    a_high_load: assert property (
        $rose(wave_out) |-> q_r.high_cnt == $past(q_r.high_len))
        else $error("high counter not loaded");
    a_write_capture: assert property (
        wr_fire && q_r.addr_s2 == `PWG_ADDR_LOW_LEN
        |=> q_r.low_len == $past(q_r.data_s2[`PWG_LEN_MSB:0]))
        else $error("low length write lost");
    a_clear_quiet: assert property (
        clear_on |=> !wave_out && count_end_pulse_n ##1 !wave_out)
        else $error("clear did not quiet outputs");
    a_high_capture: assert property (
        wr_fire && q_r.addr_s2 == `PWG_ADDR_HIGH_LEN
        |=> q_r.high_len == $past(q_r.data_s2[`PWG_LEN_MSB:0]))
        else $error("high length write lost");
    a_addr_ignored: assert property (
        wr_fire && q_r.addr_s2 != `PWG_ADDR_HIGH_LEN && q_r.addr_s2 != `PWG_ADDR_LOW_LEN
        |=> $stable(q_r.high_len) && $stable(q_r.low_len))
        else $error("undecoded address changed a length");
    a_idle_quiet: assert property (
        q_r.mode == PWG_IDLE |-> !wave_out && count_end_pulse_n)
        else $error("outputs not quiet while idle");
    a_wave_running: assert property (
        $changed(wave_out) && q_r.mode == PWG_RUN
        |-> ##[1:8] ($changed(wave_out) || start_on || clear_on))
        else $error("wave stopped alternating");

    // ------------------------------------------------------------
    // scenario covers
    // ------------------------------------------------------------

    c_wave_rise:   cover property ($rose(wave_out));
    c_full_period: cover property ($rose(wave_out) ##[2:7] $fell(wave_out) ##[2:7] $rose(wave_out));
    c_write_high:  cover property (wr_fire && q_r.addr_s2 == `PWG_ADDR_HIGH_LEN);
    c_restart:     cover property (wave_out ##1 start_on);
    c_clear_idle:  cover property (clear_on ##1 q_r.mode == PWG_IDLE);

endmodule : pwg_top

// ---- dv/pwg_host_model.sv ----
// host bus model that writes the phase length registers
`timescale 1ns/1ps
module pwg_host_model (
    input  wire logic       core_clk,
    output logic            host_strobe_n,
    output logic [7:0]      host_addr,
    output logic [7:0]      host_data
);
    // ----------------------------------------
    // write cycle
    // ----------------------------------------
    initial begin
        host_strobe_n = 1'b1;
        host_addr     = 8'hFF;
        host_data     = 8'hFF;
    end

    // four cycles low and high: one more than the sync depth needs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        host_strobe_n = 1'b0;
        host_addr     = a;
        host_data     = d;
        repeat (4) @(posedge core_clk);
        #1;
        host_strobe_n = 1'b1;
        host_addr     = ~a;
        host_data     = ~d;
        repeat (4) @(posedge core_clk);
    endtask : wr
endmodule : pwg_host_model

// ---- dv/test_programmable_duty_wave_generator.sv ----
// self-checking bench for the programmable duty wave generator
`timescale 1ns/1ps
`include "pwg_regs.svh"
module test_programmable_duty_wave_generator;
    logic        core_clk, resetn, start_n, quiesce_clear, skip, prev_w, prev_c;
    logic        host_strobe_n, wave_out, count_end_pulse_n;
    logic [7:0]  host_addr, host_data;
    logic [31:0] r;
    logic [2:0]  lo, hi;
    logic [7:0]  exp_q[$];
    int          n_fail, compares, cycles, run, seed;

    pwg_top u_pwg_top (.core_clk(core_clk), .resetn(resetn), .host_strobe_n(host_strobe_n),
        .host_addr(host_addr), .host_data(host_data), .start_n(start_n),
        .quiesce_clear(quiesce_clear), .wave_out(wave_out),
        .count_end_pulse_n(count_end_pulse_n));
    pwg_host_model u_pwg_host_model (.core_clk(core_clk), .host_strobe_n(host_strobe_n),
        .host_addr(host_addr), .host_data(host_data));

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // phase lengths measured from one wave edge to the next
    always @(posedge core_clk) begin
        #2;
        if (wave_out !== prev_w) begin
            if (!skip && exp_q.size() > 0) begin
                chk(run[7:0], exp_q.pop_front());
                chk({7'h0, prev_c}, 8'h00);
                chk({7'h0, count_end_pulse_n}, 8'h01);
            end
            if (wave_out === 1'b1) skip = 1'b0;
            run = 1;
        end else run++;
        if (prev_c === 1'b0 && count_end_pulse_n === 1'b0) chk(8'h00, 8'h01);
        prev_w = wave_out;
        prev_c = count_end_pulse_n;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 4000) begin
            n_fail++;
            end_sim();
        end
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    // start held low keeps the wave parked, so arming here cannot catch an old edge
    task automatic go(input logic [2:0] l, input logic [2:0] h);
        @(posedge core_clk) #1 start_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chk({7'h0, wave_out}, 8'h00);
        skip = 1'b1;
        repeat (2) begin
            exp_q.push_back({5'h0, h});
            exp_q.push_back({5'h0, l});
        end
        start_n = 1'b1;
        repeat (2 * (l + h) + 12) @(posedge core_clk);
        chk(8'(exp_q.size()), 8'h00);
    endtask : go

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        {resetn, quiesce_clear, prev_w, run, n_fail, compares, cycles} = '0;
        {start_n, skip, prev_c} = 3'h7;
        seed = 30;
        repeat (16) @(posedge core_clk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            r  = $random(seed);
            lo = (i == 0) ? 3'h2 : (i == 1) ? 3'h7 : 3'h2 + 3'(r[15:0] % 16'd6);
            hi = (i == 0) ? 3'h7 : (i == 1) ? 3'h2 : 3'h2 + 3'(r[31:16] % 16'd6);
            u_pwg_host_model.wr(`PWG_ADDR_LOW_LEN, {r[7:3], lo});
            u_pwg_host_model.wr(`PWG_ADDR_HIGH_LEN, {r[12:8], hi});
            u_pwg_host_model.wr(8'h02 | r[23:16], 8'hFF);
            go(lo, hi);
        end
        @(posedge core_clk) #1 quiesce_clear = 1'b1;
        repeat (4) @(posedge core_clk);
        repeat (10) @(posedge core_clk) #2 chk({6'h0, wave_out, count_end_pulse_n}, 8'h01);
        @(posedge core_clk) #1 quiesce_clear = 1'b0;
        repeat (20) @(posedge core_clk) #2 chk({6'h0, wave_out, count_end_pulse_n}, 8'h01);
        go(lo, hi);
        end_sim();
    end
endmodule : test_programmable_duty_wave_generator
